// ### src/epq_top.sv
// quadrature decoder, pulse accumulator and edge timer behind apb
module epq_top #(
	parameter int NIN = 12
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic [7:0] paddr, // byte address
	input wire logic psel, // slave select
	input wire logic penable, // access phase
	input wire logic pwrite, // write
	input wire logic [31:0] pwdata, // write data
	output logic [31:0] prdata, // read data
	output logic pready, // ready
	output logic pslverr, // error
	input wire logic [NIN-1:0] term_in, // universal terminals
	input wire logic pulse_in, // pulse input terminal
	input wire logic scan_tick, // scan start strobe
	output logic irq // level interrupt
);
	logic [NIN-1:0] term_s;
	logic pulse_s;
	logic pulse_db;
	logic [15:0] deb_ff;
	epq_pkg::epq_ctrl_s ctrl_ff;
	logic [epq_pkg::EPQ_ST_W-1:0] stat_ff, mask_ff;
	logic [31:0] tout_ff, tmin_ff;
	logic [31:0] nxt_prdata;
	logic nxt_pready, nxt_pslverr, nxt_irq;
	epq_pkg::epq_ctrl_s nxt_ctrl;
	logic [epq_pkg::EPQ_ST_W-1:0] nxt_stat, nxt_mask;
	logic [31:0] nxt_tout, nxt_tmin;
	logic [15:0] nxt_deb;
	// quadrature state
	logic qa_ff, qb_ff, pl_ff, tp_ff, tc_ff;
	logic signed [31:0] qcnt_ff, nxt_qcnt;
	logic [31:0] qup_ff, qdn_ff, nxt_qup, nxt_qdn;
	logic qdir_ff, nxt_qdir;
	logic qa, qb, step_up, step_dn;
	// pulse state
	logic [31:0] pacc_ff, nxt_pacc, pres_ff, nxt_pres;
	logic povf_ff, nxt_povf, pedge;
	// timer state
	epq_pkg::epq_tstate_e ts_ff, nxt_ts;
	logic [31:0] tcnt_ff, nxt_tcnt, tres_ff, nxt_tres;
	logic [7:0] usdiv_ff, nxt_usdiv;
	logic tnan_ff, nxt_tnan, tdone_ev, tnan_ev;
	logic tp_edge, tc_edge, tstart_ev;
	logic acc, wr, rd;

	// selects one bit of the terminal vector by terminal index
	function automatic logic pick(input logic [NIN-1:0] v, input int i);
		pick = (i < NIN) ? v[i] : 1'b0; // pairs past the last pin read low
	endfunction

	epq_sync #(.W(NIN + 1)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({pulse_in, term_in}),
		.q({pulse_s, term_s})
	);

	epq_debounce u_deb (
		.clk(pclk),
		.rst_n(presetn),
		.d(pulse_s),
		.lim(deb_ff),
		.q(pulse_db)
	);

	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;

	// channel a on the even terminal of the pair, b on the odd one
	assign qa = pick(term_s, 2 * int'(ctrl_ff.pair_sel));
	assign qb = pick(term_s, 2 * int'(ctrl_ff.pair_sel) + 1);

	// direction from which channel moved relative to the other
	always_comb begin
		step_up = 1'b0;
		step_dn = 1'b0;
		case (epq_pkg::epq_qmode_e'(ctrl_ff.qmode))
			epq_pkg::EPQ_Q_SINGLE: begin
				step_up = qa && !qa_ff && !qb;
				step_dn = !qa && qa_ff && !qb;
			end
			epq_pkg::EPQ_Q_DOUBLE: begin
				step_up = (qa != qa_ff) && (qa != qb);
				step_dn = (qa != qa_ff) && (qa == qb);
			end
			epq_pkg::EPQ_Q_QUAD: begin
				step_up = ((qa != qa_ff) && (qa != qb)) ||
					((qb != qb_ff) && (qb == qa));
				step_dn = ((qa != qa_ff) && (qa == qb)) ||
					((qb != qb_ff) && (qb != qa));
			end
			default: begin
				step_up = 1'b0;
				step_dn = 1'b0;
			end
		endcase
		if ((qa != qa_ff) && (qb != qb_ff)) begin
			// both changed at once: direction unknown, skip
			step_up = 1'b0;
			step_dn = 1'b0;
		end
	end

	// signed total, tallies and direction
	always_comb begin
		nxt_qcnt = qcnt_ff;
		nxt_qup = qup_ff;
		nxt_qdn = qdn_ff;
		nxt_qdir = qdir_ff;
		if (step_up) begin
			nxt_qcnt = qcnt_ff + 32'sd1;
			nxt_qup = qup_ff + 32'h0000_0001;
		end else if (step_dn) begin
			nxt_qcnt = qcnt_ff - 32'sd1;
			nxt_qdn = qdn_ff + 32'h0000_0001;
		end
		if (wr && paddr == epq_pkg::EPQ_ADDR_CTRL && pwdata[0]) begin
			nxt_qcnt = '0;
			nxt_qup = '0;
			nxt_qdn = '0;
		end
		nxt_qdir = (nxt_qcnt < 0);
	end

	// pulse accumulator; frequency is pres over the scan interval
	always_comb begin
		pedge = ctrl_ff.pulse_sw ? (pulse_db && !pl_ff) :
			(pulse_s && !pl_ff);
		nxt_pacc = pacc_ff + {31'h0000_0000, pedge};
		nxt_povf = povf_ff || (pedge && pacc_ff == 32'hffff_ffff);
		nxt_pres = pres_ff;
		if (scan_tick) begin
			nxt_pres = pacc_ff;
			nxt_pacc = {31'h0000_0000, pedge};
			nxt_povf = 1'b0;
		end
	end

	// edge timer: times in system cycles, result in microseconds
	assign tp_edge = pick(term_s, NIN - 1) != tp_ff;
	assign tc_edge = pick(term_s, 0) != tc_ff;
	assign tstart_ev = wr && paddr == epq_pkg::EPQ_ADDR_CTRL && pwdata[1];
	always_comb begin
		nxt_ts = ts_ff;
		nxt_tcnt = tcnt_ff;
		nxt_tres = tres_ff;
		nxt_tnan = tnan_ff;
		nxt_usdiv = usdiv_ff;
		tdone_ev = 1'b0;
		tnan_ev = 1'b0;
		case (ts_ff)
			epq_pkg::EPQ_TS_IDLE: begin
				if (tstart_ev) begin
					nxt_ts = epq_pkg::EPQ_TS_ARM;
					nxt_tcnt = '0;
				end
			end
			epq_pkg::EPQ_TS_ARM: begin
				nxt_tcnt = tcnt_ff + 32'h0000_0001;
				// cross mode starts on the last terminal
				if ((ctrl_ff.tmode == epq_pkg::EPQ_T_CROSS) ? tp_edge :
					(ctrl_ff.tmode == epq_pkg::EPQ_T_SCAN) ?
					(tc_edge || scan_tick) : tc_edge) begin
					nxt_ts = epq_pkg::EPQ_TS_RUN;
					nxt_tcnt = '0;
					nxt_usdiv = 8'h00;
				end
			end
			epq_pkg::EPQ_TS_RUN: begin
				nxt_tcnt = tcnt_ff + 32'h0000_0001;
				if (tc_edge) begin
					nxt_ts = epq_pkg::EPQ_TS_IDLE;
					nxt_tres = tcnt_ff / 32'(epq_pkg::EPQ_TICKS_PER_US);
					nxt_tnan = (tcnt_ff < tmin_ff);
					tdone_ev = !nxt_tnan;
					tnan_ev = nxt_tnan;
				end
			end
			default: nxt_ts = epq_pkg::EPQ_TS_IDLE;
		endcase
		if (ts_ff != epq_pkg::EPQ_TS_IDLE && tcnt_ff >= tout_ff) begin
			nxt_ts = epq_pkg::EPQ_TS_IDLE;
			nxt_tnan = 1'b1;
			tnan_ev = 1'b1;
			tdone_ev = 1'b0;
		end
	end

	// register writes; hardware sets win over write-one-clear
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_ctrl.tstart = 1'b0;
		nxt_ctrl.qclear = 1'b0;
		nxt_mask = mask_ff;
		nxt_tout = tout_ff;
		nxt_tmin = tmin_ff;
		nxt_deb = deb_ff;
		nxt_stat = stat_ff;
		if (wr) begin
			case (paddr)
				epq_pkg::EPQ_ADDR_CTRL: nxt_ctrl = epq_pkg::epq_ctrl_s'({
					pwdata[12:10], pwdata[9:8], pwdata[5:4],
					pwdata[2], 2'b00});
				epq_pkg::EPQ_ADDR_STAT: nxt_stat =
					stat_ff & ~pwdata[epq_pkg::EPQ_ST_W-1:0];
				epq_pkg::EPQ_ADDR_MASK: nxt_mask = pwdata[epq_pkg::EPQ_ST_W-1:0];
				epq_pkg::EPQ_ADDR_TOUT: nxt_tout = pwdata;
				epq_pkg::EPQ_ADDR_TMIN: nxt_tmin = pwdata;
				epq_pkg::EPQ_ADDR_DEB: nxt_deb = pwdata[15:0];
				default: nxt_stat = nxt_stat;
			endcase
		end
		if (scan_tick) nxt_stat[epq_pkg::EPQ_ST_SCAN] = 1'b1;
		if (scan_tick && povf_ff) nxt_stat[epq_pkg::EPQ_ST_OVF] = 1'b1;
		if (tdone_ev) nxt_stat[epq_pkg::EPQ_ST_TDONE] = 1'b1;
		if (tnan_ev) nxt_stat[epq_pkg::EPQ_ST_TNAN] = 1'b1;
		if (nxt_qdir != qdir_ff) nxt_stat[epq_pkg::EPQ_ST_QDIR] = 1'b1;
		nxt_irq = |(nxt_stat & nxt_mask);
	end

	// read mux; zero-wait slave, unmapped reads zero with error
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		nxt_pslverr = 1'b0;
		nxt_pready = psel && !penable;
		case (paddr)
			epq_pkg::EPQ_ADDR_CTRL: nxt_prdata = {19'h0_0000,
				ctrl_ff.pair_sel, ctrl_ff.qmode, 2'b00,
				ctrl_ff.tmode, 1'b0, ctrl_ff.pulse_sw, 2'b00};
			epq_pkg::EPQ_ADDR_STAT: nxt_prdata = 32'(stat_ff);
			epq_pkg::EPQ_ADDR_MASK: nxt_prdata = 32'(mask_ff);
			epq_pkg::EPQ_ADDR_QCNT: nxt_prdata = qcnt_ff;
			epq_pkg::EPQ_ADDR_QUP: nxt_prdata = qup_ff;
			epq_pkg::EPQ_ADDR_QDN: nxt_prdata = qdn_ff;
			epq_pkg::EPQ_ADDR_PRES: nxt_prdata = pres_ff;
			epq_pkg::EPQ_ADDR_TRES: nxt_prdata = {tnan_ff, tres_ff[30:0]};
			epq_pkg::EPQ_ADDR_TOUT: nxt_prdata = tout_ff;
			epq_pkg::EPQ_ADDR_TMIN: nxt_prdata = tmin_ff;
			epq_pkg::EPQ_ADDR_DEB: nxt_prdata = {16'h0000, deb_ff};
			epq_pkg::EPQ_ADDR_PCUR: nxt_prdata = {qdir_ff, 30'h0000_0000,
				povf_ff};
			default: nxt_pslverr = psel && !penable;
		endcase
	end

	// all state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
			ctrl_ff <= '0;
			stat_ff <= '0;
			mask_ff <= '0;
			tout_ff <= epq_pkg::EPQ_TOUT_RST;
			tmin_ff <= epq_pkg::EPQ_TMIN_RST;
			deb_ff <= epq_pkg::EPQ_DEB_RST;
			qa_ff <= 1'b0;
			qb_ff <= 1'b0;
			pl_ff <= 1'b0;
			tp_ff <= 1'b0;
			tc_ff <= 1'b0;
			qcnt_ff <= '0;
			qup_ff <= '0;
			qdn_ff <= '0;
			qdir_ff <= 1'b0;
			pacc_ff <= '0;
			pres_ff <= '0;
			povf_ff <= 1'b0;
			ts_ff <= epq_pkg::EPQ_TS_IDLE;
			tcnt_ff <= '0;
			tres_ff <= '0;
			tnan_ff <= 1'b0;
			usdiv_ff <= 8'h00;
		end else begin
			prdata <= nxt_prdata;
			pready <= nxt_pready;
			pslverr <= nxt_pslverr;
			irq <= nxt_irq;
			ctrl_ff <= nxt_ctrl;
			stat_ff <= nxt_stat;
			mask_ff <= nxt_mask;
			tout_ff <= nxt_tout;
			tmin_ff <= nxt_tmin;
			deb_ff <= nxt_deb;
			qa_ff <= qa;
			qb_ff <= qb;
			pl_ff <= ctrl_ff.pulse_sw ? pulse_db : pulse_s;
			tp_ff <= pick(term_s, NIN - 1);
			tc_ff <= pick(term_s, 0);
			qcnt_ff <= nxt_qcnt;
			qup_ff <= nxt_qup;
			qdn_ff <= nxt_qdn;
			qdir_ff <= nxt_qdir;
			pacc_ff <= nxt_pacc;
			pres_ff <= nxt_pres;
			povf_ff <= nxt_povf;
			ts_ff <= nxt_ts;
			tcnt_ff <= nxt_tcnt;
			tres_ff <= nxt_tres;
			tnan_ff <= nxt_tnan;
			usdiv_ff <= nxt_usdiv;
		end
	end
endmodule

// ### src/epq_pkg.sv
package epq_pkg;
	localparam logic [7:0] EPQ_ADDR_CTRL = 8'h00;
	localparam logic [7:0] EPQ_ADDR_STAT = 8'h04;
	localparam logic [7:0] EPQ_ADDR_MASK = 8'h08;
	localparam logic [7:0] EPQ_ADDR_QCNT = 8'h0c;
	localparam logic [7:0] EPQ_ADDR_QUP = 8'h10;
	localparam logic [7:0] EPQ_ADDR_QDN = 8'h14;
	localparam logic [7:0] EPQ_ADDR_PRES = 8'h18;
	localparam logic [7:0] EPQ_ADDR_TRES = 8'h1c;
	localparam logic [7:0] EPQ_ADDR_TOUT = 8'h20;
	localparam logic [7:0] EPQ_ADDR_TMIN = 8'h24;
	localparam logic [7:0] EPQ_ADDR_DEB = 8'h28;
	localparam logic [7:0] EPQ_ADDR_PCUR = 8'h2c;
	localparam int EPQ_CLK_MHZ = 200;
	localparam logic [7:0] EPQ_TICKS_PER_US = 8'(EPQ_CLK_MHZ);
	localparam logic [31:0] EPQ_TOUT_RST = 32'h0001_0000;
	localparam logic [31:0] EPQ_TMIN_RST = 32'h0000_0004;
	localparam logic [15:0] EPQ_DEB_RST = 16'h0100;
	localparam int EPQ_ST_SCAN = 0;
	localparam int EPQ_ST_OVF = 1;
	localparam int EPQ_ST_TDONE = 2;
	localparam int EPQ_ST_TNAN = 3;
	localparam int EPQ_ST_QDIR = 4;
	localparam int EPQ_ST_W = 5;
	typedef enum logic [1:0] {
		EPQ_Q_SINGLE = 2'b00,
		EPQ_Q_DOUBLE = 2'b01,
		EPQ_Q_QUAD = 2'b10
	} epq_qmode_e;
	typedef enum logic [1:0] {
		EPQ_T_SUCC = 2'b00,
		EPQ_T_CROSS = 2'b01,
		EPQ_T_SCAN = 2'b10
	} epq_tmode_e;
	typedef enum logic [1:0] {
		EPQ_TS_IDLE = 2'b00,
		EPQ_TS_ARM = 2'b01,
		EPQ_TS_RUN = 2'b10
	} epq_tstate_e;
	typedef struct packed {
		logic [2:0] pair_sel;
		logic [1:0] qmode;
		logic [1:0] tmode;
		logic pulse_sw;
		logic tstart;
		logic qclear;
	} epq_ctrl_s;
	typedef struct packed {
		logic [31:0] psel_up;
		logic [31:0] delta;
	} epq_meas_s;
endpackage

// ### src/epq_sync.sv
// two-flop synchroniser per input bit
module epq_sync #(
	parameter int W = 12
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset
	input wire logic [W-1:0] d, // raw inputs
	output logic [W-1:0] q // synchronised
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_q;
	// the first stage feeds only the second stage
	always_comb begin
		nxt_meta = d;
		nxt_q = meta_ff;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= nxt_meta;
			q <= nxt_q;
		end
	end
endmodule

// ### src/epq_debounce.sv
// holds a level until it has stayed stable for lim + 1 cycles
module epq_debounce (
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset
	input wire logic d, // synchronised input
	input wire logic [15:0] lim, // stable cycles
	output logic q // filtered level
);
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic nxt_q;
	// a bounce restarts the count, so one closure yields one edge
	always_comb begin
		nxt_cnt = 16'h0000;
		nxt_q = q;
		if (d != q) begin
			nxt_cnt = cnt_ff + 16'h0001;
			if (cnt_ff >= lim) begin
				nxt_q = d;
				nxt_cnt = 16'h0000;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 16'h0000;
			q <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			q <= nxt_q;
		end
	end
endmodule

// ### testbench/epq_top_properties.sv
// watches the register bus handshake and the interrupt output
module epq_checker (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic [7:0] paddr, // byte address
	input wire logic psel, // slave select
	input wire logic penable, // access phase
	input wire logic pwrite, // write
	input wire logic [31:0] pwdata, // write data
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic scan_tick, // scan start strobe
	input wire logic irq // level interrupt
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [31:0] msk_ff;
	logic acc;
	assign acc = psel && penable && pready && pwrite;
	// mask mirror, so the interrupt can be judged without a read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			msk_ff <= 32'h0000_0000;
		else if (acc && paddr == epq_pkg::EPQ_ADDR_MASK)
			msk_ff <= pwdata;
	end
	chk_ready_access: assert property (psel && !penable |=> pready)
		else $error("no ready in access phase");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("ready held past one cycle");
	chk_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
		else $error("ready without setup");
	chk_err_unmapped: assert property (pready && paddr > 8'h2c |-> pslverr)
		else $error("unmapped access accepted");
	chk_err_mapped: assert property (pready && paddr <= 8'h2c
		&& paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("mapped access refused");
	chk_err_zero: assert property (pready && pslverr && !pwrite
		|-> prdata == 32'h0000_0000)
		else $error("refused read not zero");
	chk_irq_masked: assert property ((msk_ff == 32'h0000_0000) [*2] |-> !irq)
		else $error("irq with mask clear");
	chk_scan_irq: assert property (msk_ff[0] && scan_tick |-> ##[1:4] irq)
		else $error("scan event gave no irq");
endmodule

bind epq_top epq_checker epq_checker_i (.pclk, .presetn, .paddr, .psel,
	.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .scan_tick,
	.irq);

// ### testbench/epq_enc_model.sv
// encoder and pulse sensor on the terminals; steps change after an edge
module epq_enc_model (
	input wire logic clk, // system clock
	output logic [11:0] term, // terminal levels
	output logic pulse // pulse terminal
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] FWD = 8'h2d;
	localparam logic [7:0] REV = 8'h1e;
	initial begin
		term = 12'h000;
		pulse = 1'b0;
	end
	// full gray cycles on pair p, channel a on the even terminal
	task automatic turn(input int p, input int n, input bit fwd,
		input int gap);
		logic [1:0] ab;
		for (int i = 0; i < 4 * n; i++) begin
			repeat (gap) @(posedge clk);
			ab = fwd ? FWD[2*(i%4)+:2] : REV[2*(i%4)+:2];
			term[2*p] <= ab[0];
			term[2*p+1] <= ab[1];
		end
	endtask
	// one closure each; bounce adds a one-cycle dropout after the rise
	task automatic pulses(input int n, input bit bounce);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			pulse <= 1'b1;
			if (bounce) begin
				@(posedge clk);
				pulse <= 1'b0;
				@(posedge clk);
				pulse <= 1'b1;
			end
			repeat (8) @(posedge clk);
			pulse <= 1'b0;
			repeat (8) @(posedge clk);
		end
	endtask
	// single transition on one terminal
	task automatic flip(input int k);
		@(posedge clk);
		term[k] <= !term[k];
	endtask
endmodule

// ### testbench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, scan_tick, irq;
	logic pulse, rerr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [11:0] term;
	logic [31:0] rng = 32'h0001_0fea;
	int errors = 0;
	int samples_checked = 0;
	int n, k, p, mul;
	// 200 MHz
	always #2.5 pclk = ~pclk;
	epq_top epq_top_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .term_in(term),
		.pulse_in(pulse), .scan_tick, .irq);
	epq_enc_model epq_enc_model_i (.clk(pclk), .term(term), .pulse(pulse));
	function automatic int rnd(input int lo, input int hi);
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return lo + int'(rng % 32'(hi - lo + 1));
	endfunction
	task automatic complete_run();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string s, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	// ready, read data and error are all taken at the access edge itself
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int t;
		t = 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && t < 20) begin
			@(posedge pclk);
			t++;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (t == 20) begin
			errors++;
			complete_run();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rc(input string s, input logic [7:0] a,
		input logic [31:0] e);
		apb(a, 1'b0, 32'h0000_0000);
		check(s, e, rdat);
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask
	task automatic tick();
		scan_tick <= 1'b1;
		@(posedge pclk);
		scan_tick <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic see(input string s, input logic e);
		@(negedge pclk);
		check(s, 32'(e), 32'(irq));
		@(posedge pclk);
	endtask
	initial begin
		presetn = 1'b0;
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0000_0000;
		scan_tick = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rc("tout", epq_pkg::EPQ_ADDR_TOUT, epq_pkg::EPQ_TOUT_RST);
		rc("tmin", epq_pkg::EPQ_ADDR_TMIN, epq_pkg::EPQ_TMIN_RST);
		rc("unmapped", 8'h40, 32'h0000_0000);
		check("slverr", 32'h0000_0001, 32'(rerr));
		wr(epq_pkg::EPQ_ADDR_DEB, 32'h0000_0002);
		// every mode: forward n cycles, then back n+k so the net goes negative
		for (int m = 0; m < 3; m++) begin
			mul = 1 << m;
			n = rnd(3, 9);
			k = rnd(1, 5);
			wr(epq_pkg::EPQ_ADDR_CTRL, 32'h0000_0401 | 32'(m << 8));
			epq_enc_model_i.turn(1, n, 1'b1, rnd(3, 6));
			cyc(6);
			rc("qcount", epq_pkg::EPQ_ADDR_QCNT, n * mul);
			rc("up", epq_pkg::EPQ_ADDR_QUP, n * mul);
			epq_enc_model_i.turn(1, n + k, 1'b0, rnd(3, 6));
			cyc(6);
			rc("qneg", epq_pkg::EPQ_ADDR_QCNT, -k * mul);
			rc("down", epq_pkg::EPQ_ADDR_QDN, (n + k) * mul);
			apb(epq_pkg::EPQ_ADDR_PCUR, 1'b0, 32'h0000_0000);
			check("dir", 32'h0000_0001, 32'(rdat[31]));
		end
		// scan boundary samples the tally and starts a fresh one
		tick();
		p = rnd(5, 30);
		epq_enc_model_i.pulses(p, 1'b0);
		cyc(4);
		tick();
		rc("pulses", epq_pkg::EPQ_ADDR_PRES, p);
		tick();
		rc("empty", epq_pkg::EPQ_ADDR_PRES, 32'h0000_0000);
		// an edge lands on the very cycle of the scan clear
		fork
			epq_enc_model_i.pulses(1, 1'b0);
			begin
				cyc(3);
				tick();
			end
		join
		tick();
		rc("restart", epq_pkg::EPQ_ADDR_PRES, 32'h0000_0001);
		wr(epq_pkg::EPQ_ADDR_CTRL, 32'h0000_0004);
		epq_enc_model_i.pulses(p, 1'b1);
		cyc(8);
		tick();
		rc("closures", epq_pkg::EPQ_ADDR_PRES, p);
		// sticky scan flag: hidden by the mask, cleared by writing one
		wr(epq_pkg::EPQ_ADDR_MASK, 32'h0000_0000);
		tick();
		see("irq off", 1'b0);
		wr(epq_pkg::EPQ_ADDR_MASK, 32'h0000_0001);
		see("irq on", 1'b1);
		wr(epq_pkg::EPQ_ADDR_STAT, 32'h0000_0001);
		see("irq clr", 1'b0);
		tick();
		see("irq scan", 1'b1);
		wr(epq_pkg::EPQ_ADDR_STAT, 32'h0000_0001);
		wr(epq_pkg::EPQ_ADDR_MASK, 32'h0000_0000);
		// timer: expiry and a too-short span are invalid, else microseconds
		wr(epq_pkg::EPQ_ADDR_TOUT, 32'h0000_0040);
		wr(epq_pkg::EPQ_ADDR_CTRL, 32'h0000_0002);
		cyc(100);
		apb(epq_pkg::EPQ_ADDR_TRES, 1'b0, 32'h0000_0000);
		check("expired", 32'h0000_0001, 32'(rdat[31]));
		wr(epq_pkg::EPQ_ADDR_TOUT, 32'h0000_1000);
		// start on terminal 0, on the last terminal, or on the scan tick
		for (int m = 0; m < 3; m++) begin
			// terminal 0 also feeds quadrature pair 0 here, no recorder beside it
			wr(epq_pkg::EPQ_ADDR_CTRL, 32'h0000_0002 | 32'(m << 4));
			cyc(10);
			if (m == 2)
				tick();
			else
				epq_enc_model_i.flip(m == 1 ? 11 : 0);
			cyc(410);
			epq_enc_model_i.flip(0);
			cyc(10);
			rc("time", epq_pkg::EPQ_ADDR_TRES, 32'h0000_0002);
		end
		// a span shorter than the minimum is refused
		wr(epq_pkg::EPQ_ADDR_TMIN, 32'h0000_0064);
		wr(epq_pkg::EPQ_ADDR_CTRL, 32'h0000_0002);
		cyc(10);
		epq_enc_model_i.flip(0);
		cyc(20);
		epq_enc_model_i.flip(0);
		cyc(10);
		apb(epq_pkg::EPQ_ADDR_TRES, 1'b0, 32'h0000_0000);
		check("fast", 32'h0000_0001, 32'(rdat[31]));
		complete_run();
	end
endmodule
